// ==== eciv_defines.svh ====
/*
 * Constants for the envelope cipher vector and keystream mask block.
 * Assumes inclusion by its bare name from the package and design modules.
 */
`ifndef ECIV_DEFINES_SVH
`define ECIV_DEFINES_SVH

`define ECIV_CH_W       4
`define ECIV_LLID_W     4
`define ECIV_ADDR_W     48
`define ECIV_TIME_W     48
`define ECIV_BLK_W      28
`define ECIV_TAG_W      6
`define ECIV_CTRL_W     8
`define ECIV_DATA_W     64
`define ECIV_MASK_ON    8'h00FF
`define ECIV_MASK_OFF   8'h0000
`define ECIV_CNT_RST    48'h0000_0000_0000
`define ECIV_CNT_STEP   48'h0000_0000_0001
`define ECIV_BLK_STEP   28'h000_0001
`define ECIV_LUT_DEPTH  16

`endif

// ==== eciv_pkg.sv ====
/*
 * Types for the envelope cipher vector and keystream mask block.
 * Assumes the defines header is on the include path.
 */
`include "eciv_defines.svh"
package eciv_pkg;

    // Which of the four vector cases this instance serves.
    typedef enum logic [1:0] {
        ECIV_HE_ENC = 2'h0,
        ECIV_HE_DEC = 2'h1,
        ECIV_TE_ENC = 2'h2,
        ECIV_TE_DEC = 2'h3
    } eciv_role_e;

    // Word classification from the data path.
    typedef enum logic [2:0] {
        ECIV_W_PAYLOAD = 3'h0,
        ECIV_W_HEADER  = 3'h1,
        ECIV_W_PACING  = 3'h2,
        ECIV_W_IEIDLE  = 3'h3,
        ECIV_W_IBIDLE  = 3'h4
    } eciv_kind_e;

    // Block pairing state, one-hot.
    typedef enum logic [2:0] {
        ECIV_S_IDLE  = 3'b001,
        ECIV_S_FIRST = 3'b010,
        ECIV_S_SECOND = 3'b100
    } eciv_state_e;

endpackage : eciv_pkg

// ==== eciv_word_mask.sv ====
/*
 * Derives the 64-bit octet mask of one 72-bit payload word.
 * Assumes control flag i belongs to data octet i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eciv_defines.svh"
module eciv_word_mask (
    input  wire logic [`ECIV_CTRL_W-1:0] ctrlFlags,
    output logic      [`ECIV_DATA_W-1:0] octetMask
);
    import eciv_pkg::*;

    // Control octets (FD, 07) get 00 so they pass unchanged; all-idle gives zero.
    genvar gi;
    generate
        for (gi = 0; gi < `ECIV_CTRL_W; gi = gi + 1) begin : g_oct
            assign octetMask[gi*8 +: 8] = ctrlFlags[gi] ? `ECIV_MASK_OFF
                                                        : `ECIV_MASK_ON;
        end
    endgenerate
endmodule : eciv_word_mask
`default_nettype wire

// ==== eciv_core.sv ====
/*
 * Envelope cipher support: initialization vector, block pairing, keystream
 * masking and bypass of non-envelope words.
 * Assumes one word per clock when wordValid, keystream supplied combinationally
 * for the current vector, and the clock enable protoTick marks protocol cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "eciv_defines.svh"
module eciv_core (
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    input  wire eciv_pkg::eciv_role_e       role,
    input  wire logic                       protoTick,
    input  wire logic                       counterLoad,
    input  wire logic [`ECIV_TIME_W-1:0]    counterLoadValue,
    input  wire logic [`ECIV_TIME_W-1:0]    roundTripTime,
    input  wire logic [`ECIV_ADDR_W-1:0]    ownStationAddress,
    input  wire logic [`ECIV_ADDR_W-1:0]    learnedHeadEndAddress,
    input  wire logic                       lutWrite,
    input  wire logic [`ECIV_LLID_W-1:0]    lutWriteIndex,
    input  wire logic [`ECIV_ADDR_W-1:0]    lutWriteAddress,
    input  wire logic                       wordValid,
    input  wire eciv_pkg::eciv_kind_e       wordKind,
    input  wire logic [`ECIV_CH_W-1:0]      wordChannel,
    input  wire logic [`ECIV_LLID_W-1:0]    headerLinkId,
    input  wire logic [`ECIV_TAG_W-1:0]     headerSlotTag,
    input  wire logic                       payloadLast,
    input  wire logic [`ECIV_CTRL_W-1:0]    wordCtrl,
    input  wire logic [`ECIV_DATA_W-1:0]    wordData,
    input  wire logic [127:0]               keystream,
    output logic      [127:0]               initVector,
    output logic                            ivStrobe,
    output logic                            slotTagMismatch,
    output logic      [127:0]               keystreamMask,
    output logic                            outValid,
    output logic      [`ECIV_CTRL_W-1:0]    outCtrl,
    output logic      [`ECIV_DATA_W-1:0]    outData,
    output logic      [`ECIV_TIME_W-1:0]    cipherCounter
);
    import eciv_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Cipher counter, address table and vector state.

    logic [`ECIV_TIME_W-1:0] counterReg;
    logic [`ECIV_TIME_W-1:0] counterNext;
    logic [`ECIV_ADDR_W-1:0] addrTable [`ECIV_LUT_DEPTH];
    logic [`ECIV_CH_W-1:0]   chReg;
    logic [`ECIV_CH_W-1:0]   chNext;
    logic [`ECIV_ADDR_W-1:0] addrReg;
    logic [`ECIV_ADDR_W-1:0] addrNext;
    logic [`ECIV_TIME_W-1:0] timeReg;
    logic [`ECIV_TIME_W-1:0] timeNext;
    logic [`ECIV_BLK_W-1:0]  blkReg;
    logic [`ECIV_BLK_W-1:0]  blkNext;
    logic                    ivStbReg;
    logic                    ivStbNext;
    logic                    tagErrReg;
    logic                    tagErrNext;
    logic [`ECIV_TIME_W-1:0] stampNow;
    logic [`ECIV_ADDR_W-1:0] addrNow;
    eciv_state_e             stateReg;
    eciv_state_e             stateNext;
    logic [`ECIV_DATA_W-1:0] firstMaskReg;
    logic [`ECIV_DATA_W-1:0] firstMaskNext;
    logic [`ECIV_DATA_W-1:0] curMask;
    logic [127:0]            ksMaskReg;
    logic [127:0]            ksMaskNext;
    logic                    oValReg;
    logic                    oValNext;
    logic [`ECIV_CTRL_W-1:0] oCtrlReg;
    logic [`ECIV_CTRL_W-1:0] oCtrlNext;
    logic [`ECIV_DATA_W-1:0] oDataReg;
    logic [`ECIV_DATA_W-1:0] oDataNext;
    logic                    isHeader;
    logic                    isPayload;

    assign isHeader  = wordValid && (wordKind == ECIV_W_HEADER);
    assign isPayload = wordValid && (wordKind == ECIV_W_PAYLOAD);

    // The counter steps only on protocol cycles so it tracks the 32-bit protocol
    // clock in lockstep; the upper bits extend it. A load restores alignment.
    always_comb begin
        counterNext = counterReg;
        if (counterLoad) begin
            counterNext = counterLoadValue;
        end else if (protoTick) begin
            counterNext = counterReg + `ECIV_CNT_STEP;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            counterReg <= `ECIV_CNT_RST;
        end else begin
            counterReg <= counterNext;
        end
    end

    // Table write only; no reset so it maps onto plain memory.
    always_ff @(posedge clk) begin
        if (lutWrite) begin
            addrTable[lutWriteIndex] <= lutWriteAddress;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Vector selection per role.

    // Terminal receive counter lags transmit by the round trip, so one register
    // serves both; the head-end uses its single counter for both directions.
    always_comb begin
        stampNow = counterReg;
        addrNow  = ownStationAddress;
        case (role)
            ECIV_HE_ENC: begin
                addrNow = ownStationAddress;
            end
            ECIV_HE_DEC: begin
                addrNow = addrTable[headerLinkId];
            end
            ECIV_TE_ENC: begin
                addrNow = ownStationAddress;
            end
            ECIV_TE_DEC: begin
                addrNow  = learnedHeadEndAddress;
                stampNow = counterReg - roundTripTime;
            end
            default: begin
                addrNow = ownStationAddress;
            end
        endcase
    end

    // Vector is latched in the header cycle itself, within one protocol cycle.
    always_comb begin
        chNext     = chReg;
        addrNext   = addrReg;
        timeNext   = timeReg;
        blkNext    = blkReg;
        ivStbNext  = 1'b0;
        tagErrNext = tagErrReg;
        if (isHeader) begin
            chNext     = wordChannel;
            addrNext   = addrNow;
            timeNext   = stampNow;
            blkNext    = '0;
            ivStbNext  = 1'b1;
            // Flags a sender that broke slot tag alignment.
            tagErrNext = (stampNow[`ECIV_TAG_W-1:0] != headerSlotTag);
        end else if (isPayload && stateReg == ECIV_S_SECOND && !payloadLast) begin
            blkNext = blkReg + `ECIV_BLK_STEP;
        end else if (isPayload && stateReg == ECIV_S_FIRST && payloadLast) begin
            blkNext = blkReg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chReg     <= '0;
            addrReg   <= '0;
            timeReg   <= `ECIV_CNT_RST;
            blkReg    <= '0;
            ivStbReg  <= 1'b0;
            tagErrReg <= 1'b0;
        end else begin
            chReg     <= chNext;
            addrReg   <= addrNext;
            timeReg   <= timeNext;
            blkReg    <= blkNext;
            ivStbReg  <= ivStbNext;
            tagErrReg <= tagErrNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Block pairing and masking.

    eciv_word_mask u_word_mask (
        .ctrlFlags (wordCtrl),
        .octetMask (curMask)
    );

    // Pairing advances only on payload words and restarts on headers; pacing and idle words fall through
    // untouched and leave state alone, so a pacing run may split a block.
    always_comb begin
        stateNext     = stateReg;
        firstMaskNext = firstMaskReg;
        ksMaskNext    = ksMaskReg;
        oValNext      = 1'b0;
        oCtrlNext     = oCtrlReg;
        oDataNext     = oDataReg;
        if (wordValid) begin
            oValNext  = 1'b1;
            oCtrlNext = wordCtrl;
            oDataNext = wordData;
        end
        case (stateReg)
            ECIV_S_IDLE: begin
                if (isHeader) begin
                    stateNext = ECIV_S_FIRST;
                end
            end
            ECIV_S_FIRST: begin
                if (isHeader) begin
                    stateNext = ECIV_S_FIRST;
                end else if (isPayload) begin
                    firstMaskNext = curMask;
                    ksMaskNext    = {curMask, {`ECIV_DATA_W{1'b0}}};
                    // First half of the block keystream; the other half unused
                    // for an odd tail.
                    oDataNext = wordData ^ (keystream[127:64] & curMask);
                    stateNext = payloadLast ? ECIV_S_IDLE : ECIV_S_SECOND;
                end
            end
            ECIV_S_SECOND: begin
                if (isHeader) begin
                    stateNext = ECIV_S_FIRST;
                end else if (isPayload) begin
                    ksMaskNext = {firstMaskReg, curMask};
                    oDataNext  = wordData ^ (keystream[63:0] & curMask);
                    stateNext  = payloadLast ? ECIV_S_IDLE : ECIV_S_FIRST;
                end
            end
            default: begin
                stateNext = ECIV_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stateReg     <= ECIV_S_IDLE;
            firstMaskReg <= '0;
            ksMaskReg    <= '0;
            oValReg      <= 1'b0;
            oCtrlReg     <= '0;
            oDataReg     <= '0;
        end else begin
            stateReg     <= stateNext;
            firstMaskReg <= firstMaskNext;
            ksMaskReg    <= ksMaskNext;
            oValReg      <= oValNext;
            oCtrlReg     <= oCtrlNext;
            oDataReg     <= oDataNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Block number sits in the low bits so the keystream core can count on it.
    assign initVector      = {chReg, addrReg, timeReg, blkReg};
    assign ivStrobe        = ivStbReg;
    assign slotTagMismatch = tagErrReg;
    assign keystreamMask   = ksMaskReg;
    assign outValid        = oValReg;
    assign outCtrl         = oCtrlReg;
    assign outData         = oDataReg;
    assign cipherCounter   = counterReg;

endmodule : eciv_core
`default_nettype wire

// ==== eciv_checker.sv ====
/* Port-level timing and value checks for the envelope cipher core.
   Assumes binding to eciv_core with a single clock domain. */
`timescale 1ns/1ps
`default_nettype none
module eciv_checker (
    input wire logic                 clk,
    input wire logic                 arst_n,
    input wire eciv_pkg::eciv_role_e role,
    input wire logic                 protoTick,
    input wire logic                 counterLoad,
    input wire logic [47:0]          ownStationAddress,
    input wire logic                 wordValid,
    input wire eciv_pkg::eciv_kind_e wordKind,
    input wire logic [3:0]           wordChannel,
    input wire logic [5:0]           headerSlotTag,
    input wire logic [7:0]           wordCtrl,
    input wire logic [63:0]          wordData,
    input wire logic [127:0]         initVector,
    input wire logic                 ivStrobe,
    input wire logic                 slotTagMismatch,
    input wire logic                 outValid,
    input wire logic [7:0]           outCtrl,
    input wire logic [63:0]          outData,
    input wire logic [47:0]          cipherCounter
);
    import eciv_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic hdr;
    logic byp;
    // Word class decodes shared by the properties below.
    assign hdr = wordValid && wordKind == ECIV_W_HEADER;
    assign byp = wordValid && wordKind inside {ECIV_W_PACING, ECIV_W_IEIDLE, ECIV_W_IBIDLE};
    AST_IV_ONE_CYCLE: assert property (hdr |=> ivStrobe)
        else $error("vector late after header");
    AST_IV_ONLY_HEADER: assert property (ivStrobe |-> $past(hdr))
        else $error("vector strobe without header");
    AST_IV_FRESH: assert property (ivStrobe |-> initVector[27:0] == 28'h000_0000 &&
        initVector[127:124] == $past(wordChannel)) else $error("bad channel or block");
    AST_OWN_ADDR: assert property (ivStrobe && $past(role) inside {ECIV_HE_ENC,
        ECIV_TE_ENC} |-> initVector[123:76] == $past(ownStationAddress))
        else $error("own address not used");
    AST_STAMP: assert property (ivStrobe && $past(role) != ECIV_TE_DEC &&
        !$past(protoTick) |-> initVector[75:28] == $past(cipherCounter))
        else $error("timestamp not latched");
    AST_TAG_FLAG: assert property (ivStrobe |->
        slotTagMismatch == ($past(headerSlotTag) != initVector[33:28]))
        else $error("slot tag flag wrong");
    AST_BYPASS: assert property (byp |=> outData == $past(wordData) &&
        $stable(initVector)) else $error("bypass word touched");
    AST_HEADER_CLEAR: assert property (hdr |=> outData == $past(wordData))
        else $error("header altered");
    AST_IDLE_CLEAR: assert property (wordValid && wordCtrl == 8'hFF |=>
        outData == $past(wordData)) else $error("all control word altered");
    AST_CTRL_PASS: assert property (wordValid |=> outValid &&
        outCtrl == $past(wordCtrl)) else $error("control flags lost");
    AST_COUNTER: assert property (protoTick && !counterLoad |=>
        cipherCounter == $past(cipherCounter) + 48'h0000_0000_0001)
        else $error("counter did not step");
endmodule : eciv_checker
////////////////////////////////////////////////////////////////////////////////
bind eciv_core eciv_checker eciv_checker_inst (.clk(clk), .arst_n(arst_n), .role(role),
    .protoTick(protoTick), .counterLoad(counterLoad), .ownStationAddress(ownStationAddress),
    .wordValid(wordValid), .wordKind(wordKind), .wordChannel(wordChannel),
    .headerSlotTag(headerSlotTag), .wordCtrl(wordCtrl), .wordData(wordData),
    .initVector(initVector), .ivStrobe(ivStrobe), .slotTagMismatch(slotTagMismatch),
    .outValid(outValid), .outCtrl(outCtrl), .outData(outData), .cipherCounter(cipherCounter));
`default_nettype wire

// ==== eciv_far_end.sv ====
/* Stand-in for the counter-mode keystream core.
   Assumes the vector is registered and answered combinationally. */
`timescale 1ns/1ps
`default_nettype none
module eciv_far_end (
    input  wire logic [127:0] initVector,
    output logic      [127:0] keystream
);
    import eciv_pkg::*;
    // A cheap scramble, not a cipher: every vector bit, block number too, moves it.
    assign keystream = ~{initVector[63:0], initVector[127:64]};
endmodule : eciv_far_end
`default_nettype wire

// ==== envelope_cipher_iv_and_mask_bench.sv ====
/* Self-checking bench for eciv_core with a keystream stand-in.
   Assumes eciv_checker is bound and eciv_far_end answers at once. */
`timescale 1ns/1ps
`default_nettype none
module envelope_cipher_iv_and_mask_bench;
    import eciv_pkg::*;
    logic clk = 1'b0, arst_n = 1'b0, protoTick = 1'b0, counterLoad = 1'b0, lutWrite = 1'b0;
    logic wordValid = 1'b0, payloadLast = 1'b0, ivStrobe, slotTagMismatch, outValid;
    eciv_role_e role = ECIV_HE_ENC;
    eciv_kind_e wordKind = ECIV_W_PAYLOAD;
    logic [3:0] lutWriteIndex = 4'h0, wordChannel = 4'h0, headerLinkId = 4'h0;
    logic [5:0] headerSlotTag = 6'h00;
    logic [7:0] wordCtrl = 8'h00, outCtrl;
    logic [63:0] wordData = '0, outData, m0;
    logic [47:0] rtt = 48'h0000_0000_0321, ownA = 48'h0A0A_0B0B_0C0C, cipherCounter;
    logic [47:0] hdA = 48'h0D0D_0E0E_0F0F, lutWriteAddress = '0, cnt, lut [16];
    logic [127:0] keystream, initVector, keystreamMask, iv = '0;
    logic [31:0] seed = 32'h0000_AD27;
    logic [200:0] qOut [$];
    logic [128:0] qIv [$];
    int ph = 0, fail_count = 0, check_count = 0;

    eciv_core eciv_core_inst (.clk(clk), .arst_n(arst_n), .role(role), .protoTick(protoTick),
        .counterLoad(counterLoad), .counterLoadValue(48'h0000_FFFF_FFF0), .roundTripTime(rtt),
        .ownStationAddress(ownA), .learnedHeadEndAddress(hdA), .lutWrite(lutWrite),
        .lutWriteIndex(lutWriteIndex), .lutWriteAddress(lutWriteAddress), .wordValid(wordValid),
        .wordKind(wordKind), .wordChannel(wordChannel), .headerLinkId(headerLinkId),
        .headerSlotTag(headerSlotTag), .payloadLast(payloadLast), .wordCtrl(wordCtrl),
        .wordData(wordData), .keystream(keystream), .initVector(initVector),
        .ivStrobe(ivStrobe), .slotTagMismatch(slotTagMismatch), .keystreamMask(keystreamMask),
        .outValid(outValid), .outCtrl(outCtrl), .outData(outData), .cipherCounter(cipherCounter));
    eciv_far_end eciv_far_end_inst (.initVector(initVector), .keystream(keystream));

    // Free-running 8 ns clock.
    always #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : nxt
    // Octet i is encrypted only when its control flag is clear.
    function automatic logic [63:0] om(input logic [7:0] c);
        for (int i = 0; i < 8; i++) om[8*i+:8] = c[i] ? 8'h00 : 8'hFF;
    endfunction : om
    task automatic cmp(input string n, input logic [127:0] e, input logic [127:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    // Drives one word and predicts its output; the model keeps the vector and pairing.
    task automatic put(input logic v, input eciv_kind_e k, input logic [7:0] c,
                       input logic [63:0] d, input logic lst, input logic [5:0] off);
        logic [31:0] r;
        logic [47:0] ts;
        logic [63:0] m, e;
        logic [127:0] ks;
        logic [128:0] mk;
        r = nxt();
        @(posedge clk);
        ts = (role == ECIV_TE_DEC) ? cnt - rtt : cnt;
        ks = ~{iv[63:0], iv[127:64]};
        m = om(c);
        e = d;
        mk = '0;
        wordValid <= v;
        wordKind <= k;
        wordCtrl <= c;
        wordData <= d;
        payloadLast <= lst;
        wordChannel <= r[15:12];
        headerLinkId <= r[11:8];
        headerSlotTag <= ts[5:0] + off;
        protoTick <= r[16] && k != ECIV_W_HEADER;
        if (v && k == ECIV_W_HEADER) begin
            iv = {r[15:12], role inside {ECIV_HE_ENC, ECIV_TE_ENC} ? ownA :
                  role == ECIV_HE_DEC ? lut[r[11:8]] : hdA, ts, 28'h000_0000};
            qIv.push_back({off != 6'h00, iv});
            ph = 1;
        end else if (v && k == ECIV_W_PAYLOAD && ph == 1) begin
            e = d ^ (ks[127:64] & m);
            m0 = m;
            ph = lst ? 0 : 2;
        end else if (v && k == ECIV_W_PAYLOAD && ph == 2) begin
            e = d ^ (ks[63:0] & m);
            mk = {1'b1, m0, m};
            iv[27:0] = lst ? iv[27:0] : iv[27:0] + 28'h000_0001;
            ph = lst ? 0 : 1;
        end
        if (v) qOut.push_back({mk, c, e});
        cnt = cnt + 48'(r[16] && k != ECIV_W_HEADER);
    endtask : put

    // Compares every produced word and vector against the model queues.
    always @(posedge clk) begin
        logic [200:0] x;
        logic [128:0] y;
        if (outValid === 1'b1) begin
            x = qOut.pop_front();
            cmp("outData", 128'(x[63:0]), 128'(outData));
            cmp("outCtrl", 128'(x[71:64]), 128'(outCtrl));
            if (x[200]) cmp("keystreamMask", x[199:72], keystreamMask);
        end
        if (ivStrobe === 1'b1) begin
            y = qIv.pop_front();
            cmp("initVector", y[127:0], initVector);
            cmp("slotTagMismatch", 128'(y[128]), 128'(slotTagMismatch));
        end
    end
    // Cuts a hang short.
    initial begin
        #200_000;
        fail_count++;
        final_report();
    end
    // Main sequence: table fill, counter load, then envelopes in every role.
    initial begin
        logic [31:0] r;
        int n;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            lut[i] = 48'({nxt(), nxt()} >> 16);
            lutWrite <= 1'b1;
            lutWriteIndex <= 4'(i);
            lutWriteAddress <= lut[i];
        end
        @(posedge clk);
        lutWrite <= 1'b0;
        counterLoad <= 1'b1;
        @(posedge clk);
        counterLoad <= 1'b0;
        cnt = 48'h0000_FFFF_FFF0;
        for (int ro = 0; ro < 4; ro++) begin
            role <= eciv_role_e'(ro);
            put(1'b1, ECIV_W_PAYLOAD, 8'h00, {nxt(), nxt()}, 1'b0, 6'h00);
            for (int en = 0; en < 4; en++) begin
                put(1'b1, ECIV_W_HEADER, 8'(nxt() >> 24), {nxt(), nxt()}, 1'b0, 6'(ro == 1 && en == 2));
                if (en == 0) put(1'b1, ECIV_W_PAYLOAD, 8'h00, {nxt(), nxt()}, 1'b0, 6'h00);
                if (en == 0) put(1'b1, ECIV_W_HEADER, 8'h00, {nxt(), nxt()}, 1'b0, 6'h00);
                n = en + 1 + ro % 2;
                for (int w = 0; w < n; w++) begin
                    r = nxt();
                    if (r[1:0] == 2'h0) repeat (33) put(1'b1, ECIV_W_PACING, r[15:8], {r, r}, 1'b0, 6'h00);
                    put(1'b1, ECIV_W_PAYLOAD, r[2] ? 8'h00 : 8'hFF >> r[5:3], {nxt(), nxt()}, w == n - 1, 6'h00);
                end
                put(r[6], ECIV_W_IEIDLE, r[15:8], {r, r}, 1'b0, 6'h00);
                put(1'b1, ECIV_W_IBIDLE, r[23:16], {r, ~r}, 1'b0, 6'h00);
            end
        end
        put(1'b0, ECIV_W_IBIDLE, 8'h00, 64'h0000_0000_0000_0000, 1'b0, 6'h00);
        @(posedge clk);
        wordValid <= 1'b0;
        protoTick <= 1'b0;
        #1 cmp("cipherCounter", 128'(cnt), 128'(cipherCounter));
        repeat (3) @(posedge clk);
        cmp("pending", 128'h0, 128'(qOut.size() + qIv.size()));
        final_report();
    end
endmodule : envelope_cipher_iv_and_mask_bench
`default_nettype wire
